// ### test_watchdog_timer_with_armed_reload.sv
// testbench: register access, armed reload, overflow and disable scenarios
`timescale 1ns/10ps
module test_watchdog_timer_with_armed_reload;
  import wdt_pkg::*;
  logic        clk = 0;
  logic        rst = 1;
  logic        en_n = 0;
  logic [31:0] awa = '0, wd = '0, ara = '0, rdat;
  logic        awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0;
  logic        awr, wr_r, bv, arr, rv, sysr, pin, idle, pwr_dn;
  logic [1:0]  bres, rres;
  int          n_mismatch = 0, check_count = 0, cyc = 0, n;
  wdt_top uut (.i_clk(clk), .i_rst(rst), .i_enable_n_pin(en_n),
    .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
    .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wr_r), .o_s_axi_bresp(bres), .o_s_axi_bvalid(bv),
    .i_s_axi_bready(brd), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv),
    .o_s_axi_arready(arr), .o_s_axi_rdata(rdat), .o_s_axi_rresp(rres),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rrd), .o_sys_reset(sysr),
    .o_reset_pin(pin), .o_idle(idle), .o_power_down(pwr_dn));
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_r) wv <= 1'b0;
      if (bv) break;
    end
    brd <= 1'b0;
    chk(32'(bres), 32'(er));
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv) break;
    end
    rrd <= 1'b0;
    chk(rdat, exp);
    chk(32'(rres), 32'(RESP_OKAY));
  endtask : rd
  task automatic t_regs;
    rd(ADDR_PWR_CTL, 32'h0);
    rd(ADDR_STATUS, 32'h1);
    wr(ADDR_WDCNT, 32'h55, RESP_OKAY);
    rd(ADDR_WDCNT, 32'h0);
    wr(32'h100, 32'h1, RESP_SLVERR);
    wr(ADDR_PWR_CTL, 32'h02, RESP_OKAY);
    rd(ADDR_PWR_CTL, 32'h0);
    $display("test registers done");
  endtask : t_regs
  task automatic t_ovf;
    wr(ADDR_PWR_CTL, 32'h11, RESP_OKAY);
    rd(ADDR_PWR_CTL, 32'h11);
    wr(ADDR_WDCNT, 32'hFF, RESP_OKAY);
    rd(ADDR_WDCNT, 32'hFF);
    rd(ADDR_PWR_CTL, 32'h01);
    chk(32'(idle), 32'h1);
    n = 0;
    while (sysr !== 1'b1 && n < 25000)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk(32'(n > 0 && n <= OSC_PER_MC * (1 << PRE_W)), 32'h1);
    n = 0;
    while (pin !== 1'b1 && n < 5)
    begin
      @(posedge clk);
      #1 n++;
    end
    n = 0;
    while (pin === 1'b1 && n < 50)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk(32'(n), 32'(RST_PULSE_MC * OSC_PER_MC));
    rd(ADDR_PWR_CTL, 32'h0);
    rd(ADDR_WDCNT, 32'h0);
    $display("test overflow done");
  endtask : t_ovf
  // reloads every 13000 cycles keep a counter at FE from overflowing
  task automatic t_keep;
    repeat (2)
    begin
      wr(ADDR_PWR_CTL, 32'h10, RESP_OKAY);
      wr(ADDR_WDCNT, 32'hFE, RESP_OKAY);
      n = 0;
      repeat (13000)
      begin
        @(posedge clk);
        #1 n += int'(sysr !== 1'b0);
      end
      chk(32'(n), 32'h0);
    end
    rd(ADDR_WDCNT, 32'hFF);
    $display("test reload in time done");
  endtask : t_keep
  task automatic t_off;
    en_n <= 1'b1;
    wr(ADDR_PWR_CTL, 32'h12, RESP_OKAY);
    rd(ADDR_PWR_CTL, 32'h12);
    chk(32'(pwr_dn), 32'h1);
    wr(ADDR_WDCNT, 32'hFF, RESP_OKAY);
    n = 0;
    repeat (25000)
    begin
      @(posedge clk);
      #1 n += int'(sysr !== 1'b0 || pin !== 1'b0);
    end
    chk(32'(n), 32'h0);
    wr(ADDR_PWR_CTL, 32'h0, RESP_OKAY);
    en_n <= 1'b0;
    $display("test disabled done");
  endtask : t_off
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      n_mismatch++;
      finish_test();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_ovf();
    t_keep();
    t_off();
    finish_test();
  end
endmodule : test_watchdog_timer_with_armed_reload

// ### wdt_core.sv
// file: watchdog prescaler, counter and overflow detector
`timescale 1ns/10ps
module wdt_core
  import wdt_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_enable_n_pin,
  input  wire logic             i_load,
  input  wire logic [CNT_W-1:0] i_load_value,
  output logic      [CNT_W-1:0] o_count,
  output logic                  o_mc_tick,
  output logic                  o_overflow
);
  typedef struct packed {
    logic [3:0]       osc;
    logic [PRE_W-1:0] pre;
    logic [CNT_W-1:0] cnt;
    logic             ovf;
  } wdt_core_st_t;

  wdt_core_st_t st;
  wdt_core_st_t next_st;
  logic         mc;
  logic         carry;

  always_comb
  begin
    next_st = st;
    mc      = (st.osc == MC_LAST);
    carry   = mc && (&st.pre);
    next_st.ovf = 1'b0;
    next_st.osc = mc ? 4'h0 : st.osc + 4'h1;
    if (!i_enable_n_pin)
    begin
      if (mc)
        next_st.pre = st.pre + 11'h001;
      if (i_load)
        next_st.cnt = i_load_value;
      else if (carry)
      begin
        next_st.cnt = st.cnt + 8'h01;
        next_st.ovf = &st.cnt;
      end
    end
    else if (i_load)
      next_st.cnt = i_load_value;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      st <= '{osc: 4'h0, pre: '0, cnt: WDCNT_RST, ovf: 1'b0};
    else
      st <= next_st;
  end

  assign o_count    = st.cnt;
  assign o_overflow = st.ovf;
  assign o_mc_tick  = (st.osc == MC_LAST);
endmodule : wdt_core

// ### wdt_pkg.sv
// package: register map, field positions and timing constants of the watchdog
package wdt_pkg;
  localparam int           OSC_PER_MC    = 12;
  localparam int           PRE_W         = 11;
  localparam int           CNT_W         = 8;
  localparam int           RST_PULSE_MC  = 3;
  localparam int           SFR_POWER_CTL = 'h87;
  localparam int           SFR_WD_COUNT  = 'hFF;
  localparam logic [31:0]  ADDR_PWR_CTL  = 32'(SFR_POWER_CTL * 4);
  localparam logic [31:0]  ADDR_WDCNT    = 32'(SFR_WD_COUNT * 4);
  localparam logic [31:0]  ADDR_STATUS   = 32'h0000_0400;
  localparam int           BIT_IDLE      = 0;
  localparam int           BIT_PWR_DN    = 1;
  localparam int           BIT_ARM       = 4;
  localparam logic [7:0]   PWR_CTL_RST   = 8'h00;
  localparam logic [7:0]   PWR_CTL_WMASK = 8'hFF;
  localparam logic [7:0]   WDCNT_RST     = 8'h00;
  localparam logic [1:0]   RESP_OKAY     = 2'h0;
  localparam logic [1:0]   RESP_SLVERR   = 2'h2;
  localparam logic [3:0]   MC_LAST       = 4'(OSC_PER_MC - 1);
  localparam logic [1:0]   PULSE_LAST    = 2'(RST_PULSE_MC - 1);
endpackage : wdt_pkg

// ### wdt_top.sv
// file: watchdog with armed reload and AXI4-Lite register slave
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
module wdt_top
  import wdt_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_enable_n_pin,
  input  wire logic [31:0] i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  input  wire logic [31:0] i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  output logic             o_sys_reset,
  output logic             o_reset_pin,
  output logic             o_idle,
  output logic             o_power_down
);
  typedef enum logic [2:0] {
    W_IDLE = 3'b001,
    W_RESP = 3'b010,
    W_HOLD = 3'b100
  } wdt_wr_t;

  typedef struct packed {
    logic         aw_got;
    logic [31:0]  aw_addr;
    logic         w_got;
    logic [7:0]   w_data;
    logic         w_lane0;
    wdt_wr_t      wst;
    logic [1:0]   bresp;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
    logic [7:0]   pwr_ctl;
    logic         pulse_on;
    logic [1:0]   pulse_mc;
    logic         sys_rst;
  } wdt_top_st_t;

  wdt_top_st_t         st;
  wdt_top_st_t         next_st;
  logic                core_rst;
  logic                load;
  logic [CNT_W-1:0]    count;
  logic                mc_tick;
  logic                overflow;
  logic                do_write;
  logic [31:0]         rd_val;

  function automatic logic [1:0] decode(input logic [31:0] addr);
    if (addr == ADDR_PWR_CTL)
      return 2'd1;
    else if (addr == ADDR_WDCNT)
      return 2'd2;
    else if (addr == ADDR_STATUS)
      return 2'd3;
    return 2'd0;
  endfunction : decode

  // watchdog reset also restarts the core prescaler and counter
  assign core_rst = i_rst || st.sys_rst;
  assign do_write = (st.wst == W_IDLE) && st.aw_got && st.w_got;
  assign load     = do_write && (decode(st.aw_addr) == 2'd2) && st.w_lane0
                    && st.pwr_ctl[BIT_ARM];

  wdt_core u_core
  (
    .i_clk          (i_clk),
    .i_rst          (core_rst),
    .i_enable_n_pin (i_enable_n_pin),
    .i_load         (load),
    .i_load_value   (st.w_data),
    .o_count        (count),
    .o_mc_tick      (mc_tick),
    .o_overflow     (overflow)
  );

  always_comb
  begin
    rd_val = 32'h0000_0000;
    case (decode(i_s_axi_araddr))
      2'd1:    rd_val = {24'h000000, st.pwr_ctl};
      2'd2:    rd_val = {24'h000000, count};
      2'd3:    rd_val = {30'h0, st.pulse_on, ~i_enable_n_pin};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    next_st = st;
    next_st.sys_rst = overflow;
    // take address and data only while the matching ready is shown
    if (i_s_axi_awvalid && (st.wst == W_IDLE) && !st.aw_got)
    begin
      next_st.aw_got  = 1'b1;
      next_st.aw_addr = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && (st.wst == W_IDLE) && !st.w_got)
    begin
      next_st.w_got   = 1'b1;
      next_st.w_data  = i_s_axi_wdata[7:0];
      next_st.w_lane0 = i_s_axi_wstrb[0];
    end
    case (st.wst)
      W_IDLE:
      begin
        if (do_write)
        begin
          next_st.wst   = W_RESP;
          next_st.bresp = (decode(st.aw_addr) == 2'd0) ? RESP_SLVERR : RESP_OKAY;
          if (decode(st.aw_addr) == 2'd1 && st.w_lane0)
          begin
            next_st.pwr_ctl = st.w_data & PWR_CTL_WMASK;
            if (!i_enable_n_pin)
              next_st.pwr_ctl[BIT_PWR_DN] = 1'b0;
          end
          if (load)
            next_st.pwr_ctl[BIT_ARM] = 1'b0;
        end
      end
      W_RESP:
      begin
        if (i_s_axi_bready)
        begin
          next_st.wst    = W_HOLD;
          next_st.aw_got = 1'b0;
          next_st.w_got  = 1'b0;
        end
      end
      W_HOLD:
        next_st.wst = W_IDLE;
      default:
        next_st.wst = W_IDLE;
    endcase
    if (st.rvalid)
    begin
      if (i_s_axi_rready)
        next_st.rvalid = 1'b0;
    end
    else if (i_s_axi_arvalid)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_val;
      next_st.rresp  = (decode(i_s_axi_araddr) == 2'd0) ? RESP_SLVERR : RESP_OKAY;
    end
    // output pulse of three machine cycles on the reset pin
    // starts the cycle after the internal reset so it aligns with the restarted prescaler
    if (st.sys_rst)
    begin
      next_st.pulse_on = 1'b1;
      next_st.pulse_mc = 2'd0;
    end
    else if (st.pulse_on && mc_tick)
    begin
      if (st.pulse_mc == PULSE_LAST)
        next_st.pulse_on = 1'b0;
      else
        next_st.pulse_mc = st.pulse_mc + 2'd1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st          <= '0;
      st.wst      <= W_IDLE;
      st.pwr_ctl  <= PWR_CTL_RST;
    end
    else if (st.sys_rst)
    begin
      st          <= next_st;
      st.pwr_ctl  <= PWR_CTL_RST;
      st.sys_rst  <= 1'b0;
    end
    else
      st <= next_st;
  end

  assign o_s_axi_awready = (st.wst == W_IDLE) && !st.aw_got;
  assign o_s_axi_wready  = (st.wst == W_IDLE) && !st.w_got;
  assign o_s_axi_bvalid  = (st.wst == W_RESP);
  assign o_s_axi_bresp   = st.bresp;
  assign o_s_axi_arready = !st.rvalid;
  assign o_s_axi_rvalid  = st.rvalid;
  assign o_s_axi_rdata   = st.rdata;
  assign o_s_axi_rresp   = st.rresp;
  assign o_sys_reset     = st.sys_rst;
  assign o_reset_pin     = st.pulse_on;
  assign o_idle          = st.pwr_ctl[BIT_IDLE];
  assign o_power_down    = st.pwr_ctl[BIT_PWR_DN];
endmodule : wdt_top

// ### wdt_top_checker.sv
// checker: timing and protocol properties of the watchdog top
`timescale 1ns/10ps
module wdt_checker
  import wdt_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_enable_n_pin,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic o_s_axi_rvalid,
  input wire logic o_sys_reset,
  input wire logic o_reset_pin,
  input wire logic o_idle,
  input wire logic o_power_down
);
  logic [7:0] pin_len;
  // cycles the reset pin has been high so far
  always_ff @(posedge i_clk)
  begin
    pin_len <= (i_rst || !o_reset_pin) ? 8'h00 : pin_len + 8'h01;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sys_pulse_a: assert property (o_sys_reset |=> !o_sys_reset)
    else $error("internal reset too long");
  pin_max_a: assert property (o_reset_pin |-> pin_len < 8'h24)
    else $error("reset pin pulse too long");
  pin_min_a: assert property ($fell(o_reset_pin) |-> pin_len == 8'h24)
    else $error("reset pin pulse wrong length");
  off_quiet_a: assert property (i_enable_n_pin && $past(i_enable_n_pin, 2) |-> !o_sys_reset)
    else $error("reset while disabled");
  down_block_a: assert property (!i_enable_n_pin && !$past(i_enable_n_pin) |-> !o_power_down)
    else $error("power down while enabled");
  idle_clear_a: assert property (o_sys_reset |-> ##[0:1] !o_idle)
    else $error("idle kept over reset");
  b_lat_a: assert property (i_s_axi_awvalid && o_s_axi_awready
    && i_s_axi_wvalid && o_s_axi_wready |-> ##2 o_s_axi_bvalid)
    else $error("write answer late");
  r_lat_a: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read answer late");
  cover property ($rose(o_reset_pin));
  cover property (o_idle && o_sys_reset);
  cover property (o_power_down);
endmodule : wdt_checker
bind wdt_top wdt_checker u_chk (.i_clk, .i_rst, .i_enable_n_pin, .i_s_axi_awvalid,
  .o_s_axi_awready, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bvalid, .i_s_axi_arvalid,
  .o_s_axi_arready, .o_s_axi_rvalid, .o_sys_reset, .o_reset_pin, .o_idle, .o_power_down);
